// >>> core/cdm_pkg.sv
package cdm_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_EXEC = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_PSW = 8'h10;
  localparam logic [7:0] ADDR_MEM_ADDR = 8'h14;
  localparam logic [7:0] ADDR_MEM_DATA = 8'h18;

  // exec register fields
  localparam int EXEC_OPC_LSB = 0;
  localparam int EXEC_IMM_LSB = 8;

  // state register bit positions
  localparam int ST_IRQ_ARMED = 0;
  localparam int ST_T0_CLK_EN = 1;
  localparam int ST_BANK_FF = 2;
  localparam int ST_REG_BANK = 3;
  localparam int ST_HALTED = 4;
  localparam int ST_IRQ_REQ = 5;

  localparam int PSW_BANK_BIT = 4;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam int MEM_DEPTH = 64;

  // opcodes
  localparam logic [7:0] OPC_IRQ_ARM = 8'h05;
  localparam logic [7:0] OPC_IRQ_MASK = 8'h15;
  localparam logic [7:0] OPC_T0_CLK = 8'h75;
  localparam logic [7:0] OPC_PBANK_LOW = 8'he5;
  localparam logic [7:0] OPC_PBANK_HIGH = 8'hf5;
  localparam logic [7:0] OPC_RBANK_LOW = 8'hc5;
  localparam logic [7:0] OPC_RBANK_HIGH = 8'hd5;
  localparam logic [7:0] OPC_HALT = 8'h01;
  localparam logic [7:0] OPC_MOV_A_IMM = 8'h23;
  localparam logic [7:0] OPC_MOV_A_PSW = 8'hc7;
  localparam logic [4:0] OPC_MOV_A_R = 5'h1f;
  localparam logic [6:0] OPC_MOV_A_IND = 7'h78;
  localparam logic [4:0] OPC_MOV_R_IMM = 5'h17;
  localparam logic [4:0] OPC_MOV_R_A = 5'h15;
  localparam logic [6:0] OPC_MOV_IND_A = 7'h50;
  localparam logic [6:0] OPC_MOV_IND_IMM = 7'h58;
  localparam logic [4:0] OPC_JMP_LOW = 5'h04;

  typedef enum logic [4:0] {
    OP_NONE, OP_IRQ_ARM, OP_IRQ_MASK, OP_T0_CLK, OP_PB_LOW, OP_PB_HIGH,
    OP_RB_LOW, OP_RB_HIGH, OP_HALT, OP_MOV_A_IMM, OP_MOV_A_R, OP_MOV_A_IND,
    OP_MOV_A_PSW, OP_MOV_R_IMM, OP_MOV_R_A, OP_MOV_IND_A, OP_MOV_IND_IMM, OP_JMP
  } cdm_op_type;

endpackage

// >>> core/cdm_exec.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - arm opcode lets low interrupt pin request vector
// - opcode 15 disarms external interrupt
// - opcode 75 drives clock onto test-zero pin
// - low program bank clears bank flip-flop
// - opcode F5 sets bank flip-flop
// - opcode C5 clears status bit 4
// - high register bank sets status bit 4
// - opcode 23 loads immediate, two cycles
// - register-to-accumulator move, index from opcode
// - indirect load via low six register bits
// - opcode C7 copies status word to accumulator
// - immediate-to-register move, two cycles
// - accumulator-to-register move, accumulator kept
// - indirect store of accumulator via register
// - indirect immediate store via register
// - jump takes top bit from bank flip-flop
module cdm_exec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin_n,
  output logic ext_irq_request,
  output logic test_zero_pin_out,
  output logic test_zero_pin_oe_n,
  output logic halted,
  output logic program_counter_top_bit
);
  import cdm_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_RUN1, S_RUN2, S_RESP} cdm_state_type;
  cdm_state_type state;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] opcode, imm, acc, processor_status_word;
  logic [11:0] pc;
  logic [5:0] mem_ptr;
  logic ext_irq_armed, t0_clk_en, t0_clk, program_bank_flipflop;
  logic irq_meta, irq_sync_n, is_exec_wr, is_mapped, commit, sw_write;
  logic opcode_pending, exec_commit;
  cdm_op_type op;
  logic register_bank_switch_bit;
  logic [5:0] wreg_addr, ptr_reg_addr, ind_addr;
  logic [7:0] wreg_val;
  logic [31:0] next_rdata;
  logic next_mem_we;
  logic [5:0] next_mem_addr;
  logic [7:0] next_mem_data;

  function automatic cdm_op_type decode(input logic [7:0] opc);
    cdm_op_type r;
    r = OP_NONE;
    if (opc == OPC_IRQ_ARM) r = OP_IRQ_ARM;
    else if (opc == OPC_IRQ_MASK) r = OP_IRQ_MASK;
    else if (opc == OPC_T0_CLK) r = OP_T0_CLK;
    else if (opc == OPC_PBANK_LOW) r = OP_PB_LOW;
    else if (opc == OPC_PBANK_HIGH) r = OP_PB_HIGH;
    else if (opc == OPC_RBANK_LOW) r = OP_RB_LOW;
    else if (opc == OPC_RBANK_HIGH) r = OP_RB_HIGH;
    else if (opc == OPC_HALT) r = OP_HALT;
    else if (opc == OPC_MOV_A_IMM) r = OP_MOV_A_IMM;
    else if (opc == OPC_MOV_A_PSW) r = OP_MOV_A_PSW;
    else if (opc[7:3] == OPC_MOV_A_R) r = OP_MOV_A_R;
    else if (opc[7:1] == OPC_MOV_A_IND) r = OP_MOV_A_IND;
    else if (opc[7:3] == OPC_MOV_R_IMM) r = OP_MOV_R_IMM;
    else if (opc[7:3] == OPC_MOV_R_A) r = OP_MOV_R_A;
    else if (opc[7:1] == OPC_MOV_IND_A) r = OP_MOV_IND_A;
    else if (opc[7:1] == OPC_MOV_IND_IMM) r = OP_MOV_IND_IMM;
    else if (opc[4:0] == OPC_JMP_LOW) r = OP_JMP;
    return r;
  endfunction

  // two-byte instructions spend a second machine cycle
  function automatic logic two_byte(input cdm_op_type o);
    return o == OP_MOV_A_IMM || o == OP_MOV_R_IMM || o == OP_MOV_IND_IMM || o == OP_JMP;
  endfunction

  assign op = decode(opcode);
  assign register_bank_switch_bit = processor_status_word[PSW_BANK_BIT];
  // bank 1 places the working registers at 24..31
  assign wreg_addr = {1'b0, {2{register_bank_switch_bit}}, opcode[2:0]};
  assign ptr_reg_addr = {1'b0, {2{register_bank_switch_bit}}, 2'b00, opcode[0]};
  assign ind_addr = mem[ptr_reg_addr][5:0];
  assign wreg_val = mem[wreg_addr];
  assign is_exec_wr = pwrite && paddr == ADDR_EXEC;
  assign commit = state == S_RESP && psel && penable;
  assign sw_write = commit && pwrite;

  always_comb begin
    is_mapped = 1'b1;
    next_rdata = '0;
    unique case (paddr)
      ADDR_EXEC: next_rdata = {16'h0000, imm, opcode};
      ADDR_ACC: next_rdata = {24'h000000, acc};
      ADDR_STATE: begin
        next_rdata[ST_IRQ_ARMED] = ext_irq_armed;
        next_rdata[ST_T0_CLK_EN] = t0_clk_en;
        next_rdata[ST_BANK_FF] = program_bank_flipflop;
        next_rdata[ST_REG_BANK] = register_bank_switch_bit;
        next_rdata[ST_HALTED] = halted;
        next_rdata[ST_IRQ_REQ] = ext_irq_request;
      end
      ADDR_PC: next_rdata = {20'h00000, pc};
      ADDR_PSW: next_rdata = {24'h000000, processor_status_word};
      ADDR_MEM_ADDR: next_rdata = {26'h0000000, mem_ptr};
      ADDR_MEM_DATA: next_rdata = {24'h000000, mem[mem_ptr]};
      default: is_mapped = 1'b0;
    endcase
  end

  // transfer sequencing; effects land only at the completing edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= S_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (psel && penable) begin
            if (is_exec_wr) begin
              state <= S_RUN1;
            end else begin
              state <= S_RESP;
              pready <= 1'b1;
              pslverr <= !is_mapped;
              prdata <= pwrite ? 32'h00000000 : next_rdata;
            end
          end
        end
        S_RUN1: begin
          if (two_byte(op)) begin
            state <= S_RUN2;
          end else begin
            state <= S_RESP;
            pready <= 1'b1;
            pslverr <= op == OP_NONE;
          end
        end
        S_RUN2: begin
          state <= S_RESP;
          pready <= 1'b1;
          pslverr <= 1'b0;
        end
        S_RESP: begin
          state <= S_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= '0;
        end
      endcase
    end
  end

  // opcode and immediate latched at the start of an exec access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opcode <= '0;
      imm <= '0;
    end else if (state == S_IDLE && psel && penable && is_exec_wr) begin
      opcode <= pwdata[EXEC_OPC_LSB +: 8];
      imm <= pwdata[EXEC_IMM_LSB +: 8];
    end
  end

  assign exec_commit = commit && opcode_pending;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opcode_pending <= 1'b0;
    end else if (state == S_RUN1) begin
      opcode_pending <= 1'b1;
    end else if (state == S_RESP) begin
      opcode_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc <= ACC_RESET;
    end else if (exec_commit) begin
      unique case (op)
        OP_MOV_A_IMM: acc <= imm;
        OP_MOV_A_R: acc <= wreg_val;
        OP_MOV_A_IND: acc <= mem[ind_addr];
        OP_MOV_A_PSW: acc <= processor_status_word;
        default: acc <= acc;
      endcase
    end else if (sw_write && paddr == ADDR_ACC) begin
      acc <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      processor_status_word <= PSW_RESET;
    end else if (exec_commit && op == OP_RB_LOW) begin
      processor_status_word[PSW_BANK_BIT] <= 1'b0;
    end else if (exec_commit && op == OP_RB_HIGH) begin
      processor_status_word[PSW_BANK_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      program_bank_flipflop <= 1'b0;
    end else if (exec_commit && op == OP_PB_LOW) begin
      program_bank_flipflop <= 1'b0;
    end else if (exec_commit && op == OP_PB_HIGH) begin
      program_bank_flipflop <= 1'b1;
    end
  end
  // bank change reaches the counter only through a jump
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc <= PC_RESET;
      program_counter_top_bit <= 1'b0;
    end else if (exec_commit && op == OP_JMP) begin
      pc <= {program_bank_flipflop, opcode[7:5], imm};
      program_counter_top_bit <= program_bank_flipflop;
    end
  end

  always_comb begin
    next_mem_we = 1'b0;
    next_mem_addr = mem_ptr;
    next_mem_data = pwdata[7:0];
    if (exec_commit) begin
      unique case (op)
        OP_MOV_R_IMM: begin
          next_mem_we = 1'b1;
          next_mem_addr = wreg_addr;
          next_mem_data = imm;
        end
        OP_MOV_R_A: begin
          next_mem_we = 1'b1;
          next_mem_addr = wreg_addr;
          next_mem_data = acc;
        end
        OP_MOV_IND_A: begin
          next_mem_we = 1'b1;
          next_mem_addr = ind_addr;
          next_mem_data = acc;
        end
        OP_MOV_IND_IMM: begin
          next_mem_we = 1'b1;
          next_mem_addr = ind_addr;
          next_mem_data = imm;
        end
        default: next_mem_we = 1'b0;
      endcase
    end else if (sw_write && paddr == ADDR_MEM_DATA) begin
      next_mem_we = 1'b1;
    end
  end
  // data memory keeps its contents through reset
  always_ff @(posedge sys_clk) begin
    if (next_mem_we) begin
      mem[next_mem_addr] <= next_mem_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_ptr <= '0;
    end else if (sw_write && paddr == ADDR_MEM_ADDR) begin
      mem_ptr <= pwdata[5:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_irq_armed <= 1'b0;
    end else if (exec_commit && op == OP_IRQ_ARM) begin
      ext_irq_armed <= 1'b1;
    end else if (exec_commit && op == OP_IRQ_MASK) begin
      ext_irq_armed <= 1'b0;
    end
  end

  // pin is asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_meta <= 1'b1;
      irq_sync_n <= 1'b1;
    end else begin
      irq_meta <= ext_irq_pin_n;
      irq_sync_n <= irq_meta;
    end
  end

  // level request; masked pin lows never reach program flow
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_irq_request <= 1'b0;
    end else begin
      ext_irq_request <= ext_irq_armed && !irq_sync_n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      halted <= 1'b0;
    end else if (exec_commit && op == OP_HALT) begin
      halted <= 1'b1;
    end else if (ext_irq_request) begin
      halted <= 1'b0;
    end
  end

  // only reset withdraws the clock output
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t0_clk_en <= 1'b0;
    end else if (exec_commit && op == OP_T0_CLK) begin
      t0_clk_en <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t0_clk <= 1'b0;
      test_zero_pin_out <= 1'b0;
      test_zero_pin_oe_n <= 1'b1;
    end else begin
      t0_clk <= t0_clk_en ? !t0_clk : 1'b0;
      test_zero_pin_out <= t0_clk;
      test_zero_pin_oe_n <= !t0_clk_en;
    end
  end

endmodule

// >>> tb/cdm_exec_sva.sv
`timescale 1ns/1ps
module cdm_exec_chk
  import cdm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_irq_pin_n,
  input wire logic ext_irq_request,
  input wire logic test_zero_pin_out,
  input wire logic test_zero_pin_oe_n,
  input wire logic halted,
  input wire logic program_counter_top_bit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_WAIT: assert property ($rose(penable) && psel |-> ##[1:3] pready)
    else $error("no answer within three cycles");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error without answer");
  AST_IRQ_PIN: assert property (ext_irq_request |-> $past(ext_irq_pin_n, 3) == 1'b0)
    else $error("request without low pin");
  AST_IRQ_WAKE: assert property ($fell(halted) |-> $past(ext_irq_request) || $past(rst))
    else $error("halt left without request");
  AST_T0_HOLD: assert property (!test_zero_pin_oe_n |=> !test_zero_pin_oe_n)
    else $error("clock output dropped");
  AST_T0_TOGGLE: assert property ($past(test_zero_pin_oe_n, 2) == 1'b0 |->
    test_zero_pin_out != $past(test_zero_pin_out))
    else $error("clock output not toggling");
  AST_PCTOP_JMP: assert property (!$stable(program_counter_top_bit) |->
    $past(rst) || $past(pready && pwrite && paddr == ADDR_EXEC && pwdata[4:0] == OPC_JMP_LOW))
    else $error("top pc bit moved without jump");
endmodule
bind cdm_exec cdm_exec_chk chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_irq_pin_n(ext_irq_pin_n),
  .ext_irq_request(ext_irq_request), .test_zero_pin_out(test_zero_pin_out),
  .test_zero_pin_oe_n(test_zero_pin_oe_n), .halted(halted),
  .program_counter_top_bit(program_counter_top_bit));

// >>> tb/control_and_data_move_exec_tb.sv
`timescale 1ns/1ps
module control_and_data_move_exec_tb;
  import cdm_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_irq_pin_n = 1'b1, pready, pslverr, ext_irq_request, halted, s;
  logic test_zero_pin_out, test_zero_pin_oe_n, program_counter_top_bit;
  logic [7:0] paddr = 8'h00, r;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] v[8];
  logic [32:0] q[$];
  int failures = 0, cmp_count = 0;
  cdm_exec dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_n(ext_irq_pin_n), .ext_irq_request(ext_irq_request),
    .test_zero_pin_out(test_zero_pin_out), .test_zero_pin_oe_n(test_zero_pin_oe_n),
    .halted(halted), .program_counter_top_bit(program_counter_top_bit));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one idle edge after release so psel never gets two updates in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e);
    int n;
    q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic ex(input logic [7:0] op, input logic [7:0] imm);
    xfer(1'b1, ADDR_EXEC, {16'h0, imm, op}, 33'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // write data is not compared, only the error flag
  always @(posedge sys_clk)
    if (pready === 1'b1 && q.size() > 0)
      chk({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
  initial begin
    r = 8'($urandom(32'he8d8));
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    rd(ADDR_ACC, {24'h0, ACC_RESET});
    rd(ADDR_PSW, {24'h0, PSW_RESET});
    rd(ADDR_STATE, 32'h0);
    rd(ADDR_PC, {20'h0, PC_RESET});
    r = 8'($urandom);
    ex(OPC_MOV_A_IMM, r);
    rd(ADDR_ACC, {24'h0, r});
    for (int i = 0; i < 8; i++) begin
      v[i] = 8'($urandom);
      ex({OPC_MOV_R_IMM, 3'(i)}, v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      ex({OPC_MOV_A_R, 3'(i)}, 8'h00);
      rd(ADDR_ACC, {24'h0, v[i]});
      xfer(1'b1, ADDR_MEM_ADDR, 32'(i), 33'h0);
      rd(ADDR_MEM_DATA, {24'h0, v[i]});
    end
    xfer(1'b1, ADDR_ACC, {24'h0, r}, 33'h0);
    ex({OPC_MOV_R_A, 3'd5}, 8'h00);
    rd(ADDR_ACC, {24'h0, r});
    xfer(1'b1, ADDR_MEM_ADDR, 32'd5, 33'h0);
    rd(ADDR_MEM_DATA, {24'h0, r});
    ex(OPC_RBANK_HIGH, 8'h00);
    rd(ADDR_PSW, 32'(1) << PSW_BANK_BIT);
    rd(ADDR_STATE, 32'(1) << ST_REG_BANK);
    ex(OPC_MOV_A_PSW, 8'h00);
    rd(ADDR_ACC, 32'(1) << PSW_BANK_BIT);
    ex({OPC_MOV_R_IMM, 3'd2}, 8'h5a);
    xfer(1'b1, ADDR_MEM_ADDR, 32'd26, 33'h0);
    rd(ADDR_MEM_DATA, 32'h5a);
    ex(OPC_RBANK_LOW, 8'h00);
    rd(ADDR_PSW, 32'h0);
    ex({OPC_MOV_A_R, 3'd2}, 8'h00);
    rd(ADDR_ACC, {24'h0, v[2]});
    // pointer bits 7..6 set, so only the low six may reach the address
    ex({OPC_MOV_R_IMM, 3'd0}, 8'hf0);
    ex({OPC_MOV_IND_IMM, 1'b0}, 8'h77);
    xfer(1'b1, ADDR_MEM_ADDR, 32'h30, 33'h0);
    rd(ADDR_MEM_DATA, 32'h77);
    ex({OPC_MOV_R_IMM, 3'd1}, 8'h61);
    xfer(1'b1, ADDR_ACC, {24'h0, r}, 33'h0);
    ex({OPC_MOV_IND_A, 1'b1}, 8'h00);
    xfer(1'b1, ADDR_MEM_ADDR, 32'h21, 33'h0);
    rd(ADDR_MEM_DATA, {24'h0, r});
    ex({OPC_MOV_A_IND, 1'b0}, 8'h00);
    rd(ADDR_ACC, 32'h77);
    ex(OPC_PBANK_HIGH, 8'h00);
    rd(ADDR_STATE, 32'(1) << ST_BANK_FF);
    chk({32'h0, program_counter_top_bit}, 33'h0);
    ex({3'h5, OPC_JMP_LOW}, 8'h34);
    rd(ADDR_PC, 32'hd34);
    ex(OPC_PBANK_LOW, 8'h00);
    chk({32'h0, program_counter_top_bit}, 33'h1);
    ex({3'h5, OPC_JMP_LOW}, 8'h34);
    rd(ADDR_PC, 32'h534);
    xfer(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
    xfer(1'b1, ADDR_EXEC, 32'h07, {1'b1, 32'h0});
    ex(OPC_IRQ_MASK, 8'h00);
    ext_irq_pin_n <= 1'b0;
    cyc(6);
    chk({32'h0, ext_irq_request}, 33'h0);
    ex(OPC_IRQ_ARM, 8'h00);
    cyc(4);
    chk({32'h0, ext_irq_request}, 33'h1);
    ext_irq_pin_n <= 1'b1;
    cyc(5);
    ex(OPC_HALT, 8'h00);
    rd(ADDR_STATE, (32'(1) << ST_IRQ_ARMED) | (32'(1) << ST_HALTED));
    ext_irq_pin_n <= 1'b0;
    cyc(6);
    chk({31'h0, ext_irq_request, halted}, 33'h2);
    ext_irq_pin_n <= 1'b1;
    ex(OPC_T0_CLK, 8'h00);
    cyc(3);
    chk({32'h0, test_zero_pin_oe_n}, 33'h0);
    s = test_zero_pin_out;
    cyc(1);
    chk({32'h0, test_zero_pin_out}, {32'h0, ~s});
    cyc(2);
    give_verdict;
  end
  initial begin
    #100000;
    failures++;
    give_verdict;
  end
endmodule
